// File: opm_pkg.sv
// Constants shared by the output pin mux and strap status block.
// Assumes a 32-bit AXI4-Lite register bus whose registers sit at four times their index.
package opm_pkg;

  // Register indices; byte address is the index shifted by WORD_SHIFT
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_SHIFT = 2;
  localparam logic [15:0] IDX_IND_CTRL = 16'h0462;
  localparam logic [15:0] IDX_CLK_CTRL = 16'h0463;
  localparam logic [15:0] IDX_STRAP = 16'h0467;

  // Reset values and writable-bit masks
  localparam logic [15:0] IND_CTRL_RST = 16'h0000;
  localparam logic [15:0] CLK_CTRL_RST = 16'h0001;
  localparam logic [15:0] IND_CTRL_WMASK = 16'h7777;
  localparam logic [15:0] CLK_CTRL_WMASK = 16'h00F7;
  localparam logic [15:0] STRAP_RST = 16'h0000;

  // Field positions
  localparam int unsigned IND0_SRC_LSB = 0;
  localparam int unsigned IND0_CLK_LSB = 4;
  localparam int unsigned IND1_SRC_LSB = 8;
  localparam int unsigned IND1_CLK_LSB = 12;
  localparam int unsigned CLKO_SRC_LSB = 0;
  localparam int unsigned CLKO_CLK_LSB = 4;
  localparam int unsigned ST_MAC3_LSB = 0;
  localparam int unsigned ST_MAC2_LSB = 2;
  localparam int unsigned ST_MAC1_LSB = 4;
  localparam int unsigned ST_MAC0_LSB = 6;
  localparam int unsigned ST_ROLE_LSB = 8;
  localparam int unsigned ST_ADDRB_LSB = 10;
  localparam int unsigned ST_ADDRA_LSB = 12;
  localparam int unsigned ST_AUTO_LSB = 14;

  // Pin source encodings, shared by all three pins
  localparam logic [2:0] SRC_FUNC = 3'h0;
  localparam logic [2:0] SRC_CLOCK = 3'h1;
  localparam logic [2:0] SRC_WAKE = 3'h2;
  localparam logic [2:0] SRC_UVOLT = 3'h3;
  localparam logic [2:0] SRC_TS_TX = 3'h4;
  localparam logic [2:0] SRC_TS_RX = 3'h5;
  localparam logic [2:0] SRC_LOW = 3'h6;
  localparam logic [2:0] SRC_HIGH = 3'h7;

  // Clock selections; the 3-bit fields are zero-extended to this width
  localparam logic [3:0] CKSEL_XTAL = 4'h0;
  localparam logic [3:0] CKSEL_TX = 4'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: opm_mux_if.sv
// Select fields and candidate sources for one output pin.
// Driven by the register block, read by one pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
interface opm_mux_if;
  logic [2:0] src_sel;
  logic [3:0] clk_sel;
  logic func_in;
  logic xtal_clk;
  logic tx_clk;
  logic wake;
  logic uvolt;
  logic ts_tx;
  logic ts_rx;
  modport ctrl (output src_sel, clk_sel, func_in, xtal_clk, tx_clk, wake, uvolt, ts_tx, ts_rx);
  modport mux (input src_sel, clk_sel, func_in, xtal_clk, tx_clk, wake, uvolt, ts_tx, ts_rx);
endinterface
`default_nettype wire

// File: opm_sync.sv
// Two-flop synchroniser for a bus of unrelated levels.
// Assumes each bit is independent; no reset so straps are valid at reset release.
`timescale 1ns/1ps
`default_nettype none
module opm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule
`default_nettype wire

// File: opm_pin_mux.sv
// One multifunction output pin: eight-way source select, registered output.
// Assumes all candidate sources are already in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module opm_pin_mux (
  input wire logic aclk,
  input wire logic aresetn,
  opm_mux_if.mux m,
  output var logic pin_q
);
  logic pin_d;
  logic clk_pick;

  always_comb begin
    // Unused clock selections park the pin low rather than guess a clock
    clk_pick = 1'b0;
    if (m.clk_sel == opm_pkg::CKSEL_XTAL) begin
      clk_pick = m.xtal_clk;
    end else if (m.clk_sel == opm_pkg::CKSEL_TX) begin
      clk_pick = m.tx_clk;
    end
    unique case (m.src_sel)
      opm_pkg::SRC_FUNC: pin_d = m.func_in;
      opm_pkg::SRC_CLOCK: pin_d = clk_pick;
      opm_pkg::SRC_WAKE: pin_d = m.wake;
      opm_pkg::SRC_UVOLT: pin_d = m.uvolt;
      opm_pkg::SRC_TS_TX: pin_d = m.ts_tx;
      opm_pkg::SRC_TS_RX: pin_d = m.ts_rx;
      opm_pkg::SRC_LOW: pin_d = 1'b0;
      opm_pkg::SRC_HIGH: pin_d = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end
endmodule
`default_nettype wire

// File: opm_top.sv
// Output pin source multiplexing for three pins and the sampled strap status register.
// Assumes an AXI4-Lite master on aclk; clock sources and straps arrive from pins.
//
// Overview of operation
// - Second indicator pin source chosen by 3-bit select, reset 000 indicator.
// - First indicator pin uses same eight-way select, reset to its indicator.
// - Clock output pin select, 000 means third indicator function, reset 001.
// - Second indicator clock choice: 000 crystal clock, 001 transmit clock.
// - First indicator clock choice: 000 crystal clock, 001 transmit clock.
// - Clock output pin clock choice 4 bits: 0000 crystal, 0001 transmit.
// - Autonomous strap reported read-only: 00 enabled, 11 disabled.
// - Receive-valid strap mode reported, giving management address bits 0 and 2.
// - Receive-error strap mode reported, giving management address bits 1 and 3.
// - Link role strap reported: 00 slave, 11 master.
// - Receive-data-0 strap mode reported, giving MAC and test bit 0.
// - Strap codes number the mode only, not the pin-level pattern.
// - Receive-data-1 strap mode reported, giving MAC and test bit 1.
// - Receive-data-2 strap mode reported, giving MAC and test bit 2.
// - Receive-data-3 strap reported; only mode 00 is valid for boards.
`timescale 1ns/1ps
`default_nettype none
module opm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output var logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  input wire logic [15:0] s_axi_araddr,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  input wire logic indicator0_func,
  input wire logic indicator1_func,
  input wire logic third_indicator_function,
  input wire logic crystal_input_clock,
  input wire logic transmit_clock,
  input wire logic wake_event,
  input wire logic undervoltage_flag,
  input wire logic ts_tx_event,
  input wire logic ts_rx_event,
  input wire logic [1:0] strap_auto_mode,
  input wire logic [1:0] strap_addr_a_mode,
  input wire logic [1:0] strap_addr_b_mode,
  input wire logic [1:0] strap_role_mode,
  input wire logic [1:0] strap_mac0_mode,
  input wire logic [1:0] strap_mac1_mode,
  input wire logic [1:0] strap_mac2_mode,
  input wire logic [1:0] strap_mac3_mode,
  output var logic first_indicator_pin,
  output var logic second_indicator_pin,
  output var logic clock_output_pin
);

  function automatic logic [15:0] word_idx(input logic [15:0] a);
    return a >> opm_pkg::WORD_SHIFT;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}};
    return (old & ~(lane & wmask)) | (wd & lane & wmask);
  endfunction

  // Pin-side inputs from foreign domains
  logic [15:0] strap_s;
  logic [1:0] clk_s;
  logic xtal_s;
  logic txclk_s;

  opm_sync #(.W(16)) u_strap_sync (
    .aclk(aclk),
    .d({strap_auto_mode, strap_addr_a_mode, strap_addr_b_mode, strap_role_mode,
        strap_mac0_mode, strap_mac1_mode, strap_mac2_mode, strap_mac3_mode}),
    .q(strap_s)
  );

  opm_sync #(.W(2)) u_clk_sync (
    .aclk(aclk),
    .d({crystal_input_clock, transmit_clock}),
    .q(clk_s)
  );

  assign xtal_s = clk_s[1];
  assign txclk_s = clk_s[0];

  // Strap capture
  logic [15:0] strap_q, strap_d;
  logic captured_q, captured_d;

  always_comb begin
    strap_d = strap_q;
    captured_d = captured_q;
    if (!captured_q) begin
      // mode numbers stored as delivered, no remapping to pin levels
      strap_d = strap_s;
      captured_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q <= opm_pkg::STRAP_RST;
      captured_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
      captured_q <= captured_d;
    end
  end

  // Control registers and AXI4-Lite write channel
  logic [15:0] ind_ctrl_q, ind_ctrl_d;
  logic [15:0] clk_ctrl_q, clk_ctrl_d;
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [15:0] awaddr_q, awaddr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [1:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;

  always_comb begin
    ind_ctrl_d = ind_ctrl_q;
    clk_ctrl_d = clk_ctrl_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata[15:0];
      wstrb_d = s_axi_wstrb[1:0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Commit one cycle after both halves are held
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = opm_pkg::RESP_OKAY;
      // reserved bits masked off on write
      if (word_idx(awaddr_q) == opm_pkg::IDX_IND_CTRL) begin
        ind_ctrl_d = merge(ind_ctrl_q, wdata_q, wstrb_q, opm_pkg::IND_CTRL_WMASK);
      end else if (word_idx(awaddr_q) == opm_pkg::IDX_CLK_CTRL) begin
        clk_ctrl_d = merge(clk_ctrl_q, wdata_q, wstrb_q, opm_pkg::CLK_CTRL_WMASK);
      end else if (word_idx(awaddr_q) != opm_pkg::IDX_STRAP) begin
        bresp_d = opm_pkg::RESP_SLVERR;
      end
    end
    // Ready stays low while a half is parked or a response is pending
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_ctrl_q <= opm_pkg::IND_CTRL_RST;
      clk_ctrl_q <= opm_pkg::CLK_CTRL_RST;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= opm_pkg::RESP_OKAY;
    end else begin
      ind_ctrl_q <= ind_ctrl_d;
      clk_ctrl_q <= clk_ctrl_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // AXI4-Lite read channel
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = opm_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (word_idx(s_axi_araddr) == opm_pkg::IDX_IND_CTRL) begin
        rdata_d[15:0] = ind_ctrl_q;
      end else if (word_idx(s_axi_araddr) == opm_pkg::IDX_CLK_CTRL) begin
        rdata_d[15:0] = clk_ctrl_q;
      end else if (word_idx(s_axi_araddr) == opm_pkg::IDX_STRAP) begin
        rdata_d[15:0] = strap_q;
      end else begin
        rresp_d = opm_pkg::RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= opm_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Pin multiplexers
  opm_mux_if ind0_if ();
  opm_mux_if ind1_if ();
  opm_mux_if clko_if ();

  // first indicator source and its clock choice
  assign ind0_if.src_sel = ind_ctrl_q[opm_pkg::IND0_SRC_LSB +: 3];
  assign ind0_if.clk_sel = {1'b0, ind_ctrl_q[opm_pkg::IND0_CLK_LSB +: 3]};
  assign ind0_if.func_in = indicator0_func;
  // second indicator source and its clock choice
  assign ind1_if.src_sel = ind_ctrl_q[opm_pkg::IND1_SRC_LSB +: 3];
  assign ind1_if.clk_sel = {1'b0, ind_ctrl_q[opm_pkg::IND1_CLK_LSB +: 3]};
  assign ind1_if.func_in = indicator1_func;
  // clock pin source, code 000 is the third indicator; 4-bit clock choice
  assign clko_if.src_sel = clk_ctrl_q[opm_pkg::CLKO_SRC_LSB +: 3];
  assign clko_if.clk_sel = clk_ctrl_q[opm_pkg::CLKO_CLK_LSB +: 4];
  assign clko_if.func_in = third_indicator_function;

  assign ind0_if.xtal_clk = xtal_s;
  assign ind0_if.tx_clk = txclk_s;
  assign ind0_if.wake = wake_event;
  assign ind0_if.uvolt = undervoltage_flag;
  assign ind0_if.ts_tx = ts_tx_event;
  assign ind0_if.ts_rx = ts_rx_event;
  assign ind1_if.xtal_clk = xtal_s;
  assign ind1_if.tx_clk = txclk_s;
  assign ind1_if.wake = wake_event;
  assign ind1_if.uvolt = undervoltage_flag;
  assign ind1_if.ts_tx = ts_tx_event;
  assign ind1_if.ts_rx = ts_rx_event;
  assign clko_if.xtal_clk = xtal_s;
  assign clko_if.tx_clk = txclk_s;
  assign clko_if.wake = wake_event;
  assign clko_if.uvolt = undervoltage_flag;
  assign clko_if.ts_tx = ts_tx_event;
  assign clko_if.ts_rx = ts_rx_event;

  opm_pin_mux u_ind0 (.aclk(aclk), .aresetn(aresetn), .m(ind0_if), .pin_q(first_indicator_pin));
  opm_pin_mux u_ind1 (.aclk(aclk), .aresetn(aresetn), .m(ind1_if), .pin_q(second_indicator_pin));
  opm_pin_mux u_clko (.aclk(aclk), .aresetn(aresetn), .m(clko_if), .pin_q(clock_output_pin));

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_capture;
    !captured_q;
  endsequence

  sequence s_rd_strap;
    s_axi_arvalid && arready_q && (word_idx(s_axi_araddr) == opm_pkg::IDX_STRAP);
  endsequence

  property p_ind1_const;
    (ind_ctrl_q[10:8] == opm_pkg::SRC_HIGH) ##1 (ind_ctrl_q[10:8] == opm_pkg::SRC_LOW)
      |=> !second_indicator_pin;
  endproperty
  a_ind1_const: assert property (p_ind1_const) else $error("second pin not low");

  property p_ind0_func;
    (ind_ctrl_q[2:0] == opm_pkg::SRC_FUNC) |=> first_indicator_pin == $past(indicator0_func);
  endproperty
  a_ind0_func: assert property (p_ind0_func) else $error("first pin not indicator");

  property p_clko_third;
    (clk_ctrl_q[2:0] == opm_pkg::SRC_FUNC)
      |=> clock_output_pin == $past(third_indicator_function);
  endproperty
  a_clko_third: assert property (p_clko_third) else $error("clock pin not third func");

  property p_ind1_txclk;
    (ind_ctrl_q[10:8] == opm_pkg::SRC_CLOCK) && (ind_ctrl_q[14:12] == 3'h1)
      |=> second_indicator_pin == $past(txclk_s);
  endproperty
  a_ind1_txclk: assert property (p_ind1_txclk) else $error("second pin not tx clock");

  property p_ind0_xtal;
    (ind_ctrl_q[2:0] == opm_pkg::SRC_CLOCK) && (ind_ctrl_q[6:4] == 3'h0)
      |=> first_indicator_pin == $past(xtal_s);
  endproperty
  a_ind0_xtal: assert property (p_ind0_xtal) else $error("first pin not crystal clock");

  property p_clko_clk;
    (clk_ctrl_q[2:0] == opm_pkg::SRC_CLOCK) && (clk_ctrl_q[7:4] == opm_pkg::CKSEL_TX)
      |=> clock_output_pin == $past(txclk_s);
  endproperty
  a_clko_clk: assert property (p_clko_clk) else $error("clock pin not tx clock");

  property p_strap_read;
    s_rd_strap |=> s_axi_rvalid && (s_axi_rdata == {16'h0000, strap_q});
  endproperty
  a_strap_read: assert property (p_strap_read) else $error("strap read mismatch");

  property p_cap_addr_a;
    s_capture |=> strap_q[13:12] == $past(strap_s[13:12]);
  endproperty
  a_cap_addr_a: assert property (p_cap_addr_a) else $error("addr A strap not caught");

  property p_cap_addr_b;
    s_capture |=> strap_q[11:10] == $past(strap_s[11:10]);
  endproperty
  a_cap_addr_b: assert property (p_cap_addr_b) else $error("addr B strap not caught");

  property p_cap_role;
    s_capture |=> strap_q[9:8] == $past(strap_s[9:8]);
  endproperty
  a_cap_role: assert property (p_cap_role) else $error("role strap not caught");

  property p_cap_mac0;
    s_capture |=> strap_q[7:6] == $past(strap_s[7:6]);
  endproperty
  a_cap_mac0: assert property (p_cap_mac0) else $error("mac0 strap not caught");

  property p_cap_mac1;
    s_capture |=> strap_q[5:4] == $past(strap_s[5:4]);
  endproperty
  a_cap_mac1: assert property (p_cap_mac1) else $error("mac1 strap not caught");

  property p_cap_mac2;
    s_capture |=> strap_q[3:2] == $past(strap_s[3:2]);
  endproperty
  a_cap_mac2: assert property (p_cap_mac2) else $error("mac2 strap not caught");

  property p_cap_mac3;
    s_capture |=> (strap_q[1:0] == $past(strap_s[1:0])) && captured_q;
  endproperty
  a_cap_mac3: assert property (p_cap_mac3) else $error("mac3 strap not caught");

  property p_strap_hold;
    captured_q |=> $stable(strap_q) [*8];
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_rsvd_zero;
    ((ind_ctrl_q & ~opm_pkg::IND_CTRL_WMASK) == 16'h0000)
      && ((clk_ctrl_q & ~opm_pkg::CLK_CTRL_WMASK) == 16'h0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

endmodule
`default_nettype wire

// File: opm_board_model.sv
// Board side of the pin mux: strap resistors, two clock sources, pin edge counters.
// Assumes pins are sampled on aclk; clr restarts every pin edge counter.
`timescale 1ns/1ps
`default_nettype none
module opm_board_model #(
  parameter logic [15:0] STRAP_A = 16'h0000,
  parameter logic [15:0] STRAP_B = 16'h0000
) (
  input wire logic aclk,
  input wire logic alt,
  input wire logic clr,
  input wire logic [2:0] pins,
  output var logic xtal,
  output var logic txck,
  output var logic [15:0] strap,
  output var logic [2:0][7:0] tgl
);
  logic [4:0] xc_q = 5'h00;
  logic [4:0] tc_q = 5'h00;
  logic xt_q = 1'h0;
  logic tx_q = 1'h0;
  logic [2:0] prev_q = 3'h0;
  logic [2:0][7:0] cnt_q = '0;
  // mode codes, data-3 strapped to mode 0
  always_comb strap = alt ? {STRAP_B[15:2], 2'h0} : {STRAP_A[15:2], 2'h0};
  assign xtal = xt_q;
  assign txck = tx_q;
  assign tgl = cnt_q;
  // Periods of 40 and 24 cycles give fixed edge counts in a 120-cycle window
  always @(posedge aclk) begin
    xc_q <= (xc_q == 5'h13) ? 5'h00 : xc_q + 5'h01;
    tc_q <= (tc_q == 5'h0B) ? 5'h00 : tc_q + 5'h01;
    if (xc_q == 5'h13) xt_q <= ~xt_q;
    if (tc_q == 5'h0B) tx_q <= ~tx_q;
    prev_q <= pins;
    for (int i = 0; i < 3; i++) begin
      cnt_q[i] <= clr ? 8'h00 : cnt_q[i] + {7'h00, pins[i] ^ prev_q[i]};
    end
  end
endmodule
`default_nettype wire

// File: output_pin_mux_strap_status_tb.sv
// Self-checking bench for the pin mux and strap status block.
// Assumes opm_top and opm_board_model; register bus is driven as an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module output_pin_mux_strap_status_tb;
  localparam logic [15:0] STRAP_A = {2'h3, 2'h1, 2'h2, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
  localparam logic [15:0] STRAP_B = {2'h0, 2'h2, 2'h1, 2'h3, 2'h1, 2'h0, 2'h3, 2'h0};
  localparam logic [15:0] A_IND = opm_pkg::IDX_IND_CTRL << opm_pkg::WORD_SHIFT;
  localparam logic [15:0] A_CLK = opm_pkg::IDX_CLK_CTRL << opm_pkg::WORD_SHIFT;
  localparam logic [15:0] A_ST = opm_pkg::IDX_STRAP << opm_pkg::WORD_SHIFT;
  localparam logic [15:0] A_BAD = 16'h1190;
  logic aclk = 1'h0, aresetn = 1'h0, alt = 1'h0, clr = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [6:0] srcv = 7'h00;
  logic awready, wready, bvalid, arready, rvalid, xtal, txck;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] pins;
  logic [15:0] strap;
  logic [2:0][7:0] tgl;
  int error_cnt = 0, checked = 0, cyc = 0;

  opm_top u_opm_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .indicator0_func(srcv[0]), .indicator1_func(srcv[1]),
    .third_indicator_function(srcv[2]), .crystal_input_clock(xtal), .transmit_clock(txck),
    .wake_event(srcv[3]), .undervoltage_flag(srcv[4]),
    .ts_tx_event(srcv[5]), .ts_rx_event(srcv[6]),
    .strap_auto_mode(strap[15:14]), .strap_addr_a_mode(strap[13:12]),
    .strap_addr_b_mode(strap[11:10]), .strap_role_mode(strap[9:8]),
    .strap_mac0_mode(strap[7:6]), .strap_mac1_mode(strap[5:4]),
    .strap_mac2_mode(strap[3:2]), .strap_mac3_mode(strap[1:0]),
    .first_indicator_pin(pins[0]), .second_indicator_pin(pins[1]),
    .clock_output_pin(pins[2]));

  opm_board_model #(.STRAP_A(STRAP_A), .STRAP_B(STRAP_B)) u_opm_board_model (
    .aclk(aclk), .alt(alt), .clr(clr), .pins(pins), .xtal(xtal), .txck(txck),
    .strap(strap), .tgl(tgl));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ceiling well above the roughly 1700 cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Entered just after an edge; leaves one edge after releasing bready
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rdck(input logic [15:0] a, input logic [15:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge aclk);
    chk_word("rdata", {16'h0000, e}, d);
    chk_word("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic wok(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk_word("bresp", {30'h0, opm_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  task automatic count(input int p, input logic [7:0] e);
    repeat (5) @(posedge aclk);
    clr <= 1'h1;
    @(posedge aclk);
    clr <= 1'h0;
    // Read at the next edge so exactly 120 sampled intervals are counted
    repeat (121) @(posedge aclk);
    chk_word("pin edges", {24'h0, e}, {24'h0, tgl[p]});
  endtask

  function automatic logic exp_pin(input int p, input int c, input logic pol);
    if (c == 6) return 1'h0;
    if (c == 7) return 1'h1;
    if (c == 0) return (p == 1) ? ~pol : pol;
    return c[0] ? pol : ~pol;
  endfunction

  task automatic t_reset;
    rdck(A_IND, opm_pkg::IND_CTRL_RST, opm_pkg::RESP_OKAY);
    rdck(A_CLK, 16'h0001, opm_pkg::RESP_OKAY);
    rdck(A_ST, STRAP_A, opm_pkg::RESP_OKAY);
    count(2, 8'h06);
    $display("reset values done");
  endtask

  task automatic t_regs;
    logic [1:0] r;
    wok(A_IND, 32'hFFFF_FFFF);
    rdck(A_IND, 16'h7777, opm_pkg::RESP_OKAY);
    wok(A_CLK, 32'hFFFF_FFFF);
    rdck(A_CLK, 16'h00F7, opm_pkg::RESP_OKAY);
    wok(A_ST, 32'h0000_0000);
    rdck(A_ST, STRAP_A, opm_pkg::RESP_OKAY);
    wr(A_BAD, 32'h0000_FFFF, r);
    chk_word("bresp", {30'h0, opm_pkg::RESP_SLVERR}, {30'h0, r});
    rdck(A_BAD, 16'h0000, opm_pkg::RESP_SLVERR);
    $display("register access done");
  endtask

  task automatic t_src;
    for (int pol = 0; pol < 2; pol++) begin
      srcv <= (pol == 1) ? 7'h55 : 7'h2A;
      for (int p = 0; p < 3; p++) begin
        for (int c = 0; c < 8; c++) begin
          if (c != 1) begin
            wok((p == 2) ? A_CLK : A_IND, (p == 1) ? 32'(c) << 8 : 32'(c));
            repeat (3) @(posedge aclk);
            chk_pin("pin level", exp_pin(p, c, pol[0]), pins[p]);
          end
        end
      end
    end
    // Constant high straight to constant low on the second pin
    wok(A_IND, 32'h0000_0700);
    chk_pin("second pin high", 1'h1, pins[1]);
    wok(A_IND, 32'h0000_0600);
    chk_pin("second pin low", 1'h0, pins[1]);
    $display("source select done");
  endtask

  task automatic t_clk;
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        wok((p == 2) ? A_CLK : A_IND,
            (p == 1) ? (32'(k) << 12) | 32'h100 : (32'(k) << 4) | 32'h1);
        count(p, (k == 0) ? 8'h06 : (k == 1) ? 8'h0A : 8'h00);
      end
    end
    $display("clock select done");
  endtask

  task automatic t_hold;
    alt <= 1'h1;
    repeat (4) @(posedge aclk);
    rdck(A_ST, STRAP_A, opm_pkg::RESP_OKAY);
    aresetn <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdck(A_ST, STRAP_B, opm_pkg::RESP_OKAY);
    rdck(A_IND, opm_pkg::IND_CTRL_RST, opm_pkg::RESP_OKAY);
    $display("strap hold done");
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_src();
    t_clk();
    t_hold();
    close_out();
  end
endmodule
`default_nettype wire
